//--- dsc_device.sv
// Converter side: registers, calibration divider and two channel engines
// Summary of operation
// R1: Calibration clock divides converter clock, 32 to 2048
// R2: Host keeps calibration clock in 0.5-4 MHz
// R3: Each channel has its own calibration engine
// R4: Calibration clock runs only while enable set
// R5: Control bits 4, 5 pick I, Q
// R6: Memory control zero write clears uncalibrated flags
// R7: Start bit begins calibration, about 300 ticks
// R8: Status bits 6, 7 report completion
// R9: Host clears memory control then clock enable
// R10: Thirty-two coefficients readable and writable
// R11: Address register selects coefficient, starting at one
// R12: Read bit exposes six-bit coefficient data
// R13: Write bit lets data writes load coefficients
// R14: Host selects one channel during coefficient access
// R15: Reference trim low six bits shift band gap
// R16: Reference trim code is two's complement
// R17: Coarse gain codes two's complement, per channel
// R18: Fine gain codes straight binary, per channel
// R19: All registers reached over the serial link
// R20: Divider ratio is 32 shifted by select
`timescale 1ns/1ps
module dsc_device (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  dsc_if.device bus,
  output logic signed [5:0] reference_trim_o,
  output logic signed [5:0] i_coarse_gain_code_o,
  output logic signed [5:0] q_coarse_gain_code_o,
  output logic [5:0] i_fine_gain_o,
  output logic [5:0] q_fine_gain_o,
  output logic cal_clock_o
);
  import dsc_pkg::*;
  logic [7:0] i_fine_reg, i_coarse_reg, q_fine_reg, q_coarse_reg, ref_trim_reg;
  logic [7:0] cal_ctrl_reg, coef_addr_reg, mem_ctrl_reg;
  logic [7:0] i_fine_next, i_coarse_next, q_fine_next, q_coarse_next, ref_trim_next;
  logic [7:0] cal_ctrl_next, coef_addr_next, mem_ctrl_next;
  logic ack_reg, ack_next;
  logic [7:0] rdata_reg, rdata_next;
  logic [10:0] div_reg, div_next;
  logic cal_clk_reg, cal_clk_next;
  logic tick;
  logic [10:0] div_limit;
  logic wr_hit;
  logic mem_clear;
  logic [5:0] rdata_i, rdata_q;
  logic done_i, done_q, uncal_i, uncal_q;
  logic [4:0] coef_index;
  logic we_i, we_q;
  logic [2:0] cal_clock_divide_select;
  logic [7:0] status;
  // Divider ratio 32 shifted left by select, capped at 2048
  assign cal_clock_divide_select = cal_ctrl_reg[DSC_CAL_CLOCK_DIVIDE_SELECT_LSB +: 3];
  assign div_limit = (cal_clock_divide_select > 3'(DSC_CAL_CLOCK_DIVIDE_SELECT_MAX)) ? 11'h7FF :
    11'((DSC_DIV_BASE << cal_clock_divide_select) - 1); // see R20
  always_comb begin
    div_next = div_reg;
    cal_clk_next = cal_clk_reg;
    tick = 1'b0;
    if (!cal_ctrl_reg[DSC_CLK_EN_BIT]) begin // see R4
      div_next = 11'h000;
      cal_clk_next = 1'b0;
    end else if (div_reg >= div_limit) begin
      div_next = 11'h000;
      tick = 1'b1; // see R1
      cal_clk_next = 1'b1;
    end else begin
      div_next = div_reg + 11'h001;
      if (div_reg == (div_limit >> 1)) begin
        cal_clk_next = 1'b0;
      end
    end
  end
  // Divider count and calibration clock level
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      div_reg <= 11'h000;
      cal_clk_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      cal_clk_reg <= cal_clk_next;
    end
  end
  // Write decode and read mux for the register link
  assign wr_hit = bus.req && bus.wr && !ack_reg;
  assign mem_clear = wr_hit && bus.addr == DSC_ADDR_MEM_CTRL && bus.wdata == DSC_MEM_CLEAR;
  assign status = {done_q, done_i, 4'h0, uncal_q, uncal_i}; // see R8
  always_comb begin
    i_fine_next = i_fine_reg;
    i_coarse_next = i_coarse_reg;
    q_fine_next = q_fine_reg;
    q_coarse_next = q_coarse_reg;
    ref_trim_next = ref_trim_reg;
    cal_ctrl_next = cal_ctrl_reg;
    coef_addr_next = coef_addr_reg;
    mem_ctrl_next = mem_ctrl_reg;
    ack_next = 1'b0;
    rdata_next = rdata_reg;
    if (bus.req && !ack_reg) begin // see R19
      ack_next = 1'b1;
      if (bus.wr) begin
        unique case (bus.addr)
          DSC_ADDR_I_FINE: i_fine_next = {2'b00, bus.wdata[5:0]};
          DSC_ADDR_I_COARSE: i_coarse_next = {2'b00, bus.wdata[5:0]};
          DSC_ADDR_Q_FINE: q_fine_next = {2'b00, bus.wdata[5:0]};
          DSC_ADDR_Q_COARSE: q_coarse_next = {2'b00, bus.wdata[5:0]};
          DSC_ADDR_REF_TRIM: ref_trim_next = {2'b00, bus.wdata[5:0]}; // see R15
          DSC_ADDR_CAL_CTRL: cal_ctrl_next = {2'b00, bus.wdata[5:0]};
          DSC_ADDR_COEF_ADDR: coef_addr_next = bus.wdata;
          DSC_ADDR_MEM_CTRL: mem_ctrl_next = bus.wdata;
          default: ;
        endcase
      end else begin
        unique case (bus.addr)
          DSC_ADDR_I_FINE: rdata_next = i_fine_reg;
          DSC_ADDR_I_COARSE: rdata_next = i_coarse_reg;
          DSC_ADDR_Q_FINE: rdata_next = q_fine_reg;
          DSC_ADDR_Q_COARSE: rdata_next = q_coarse_reg;
          DSC_ADDR_REF_TRIM: rdata_next = ref_trim_reg;
          DSC_ADDR_CAL_CTRL: rdata_next = cal_ctrl_reg;
          DSC_ADDR_CAL_STAT: rdata_next = status;
          DSC_ADDR_COEF_ADDR: rdata_next = coef_addr_reg;
          DSC_ADDR_COEF_DATA: begin
            if (mem_ctrl_reg[DSC_RD_BIT]) begin // see R12
              rdata_next = {2'b00, cal_ctrl_reg[DSC_TGT_I_BIT] ? rdata_i : rdata_q};
            end else begin
              rdata_next = DSC_RESET_VAL;
            end
          end
          DSC_ADDR_MEM_CTRL: rdata_next = mem_ctrl_reg;
          default: rdata_next = DSC_RESET_VAL;
        endcase
      end
    end
  end
  // Register bank, link answer and read data
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      i_fine_reg <= DSC_RESET_VAL;
      i_coarse_reg <= DSC_RESET_VAL;
      q_fine_reg <= DSC_RESET_VAL;
      q_coarse_reg <= DSC_RESET_VAL;
      ref_trim_reg <= DSC_RESET_VAL;
      cal_ctrl_reg <= DSC_RESET_VAL;
      coef_addr_reg <= DSC_RESET_VAL;
      mem_ctrl_reg <= DSC_RESET_VAL;
      ack_reg <= 1'b0;
      rdata_reg <= DSC_RESET_VAL;
    end else begin
      i_fine_reg <= i_fine_next;
      i_coarse_reg <= i_coarse_next;
      q_fine_reg <= q_fine_next;
      q_coarse_reg <= q_coarse_next;
      ref_trim_reg <= ref_trim_next;
      cal_ctrl_reg <= cal_ctrl_next;
      coef_addr_reg <= coef_addr_next;
      mem_ctrl_reg <= mem_ctrl_next;
      ack_reg <= ack_next;
      rdata_reg <= rdata_next;
    end
  end
  // Coefficient address 1..32 maps to slot 0..31
  assign coef_index = 5'(coef_addr_reg - DSC_FIRST_COEF); // see R11
  assign we_i = wr_hit && bus.addr == DSC_ADDR_COEF_DATA && mem_ctrl_reg[DSC_WR_BIT]
    && cal_ctrl_reg[DSC_TGT_I_BIT]; // see R13
  assign we_q = wr_hit && bus.addr == DSC_ADDR_COEF_DATA && mem_ctrl_reg[DSC_WR_BIT]
    && cal_ctrl_reg[DSC_TGT_Q_BIT]; // see R5
  // Independent engines per channel
  dsc_cal_engine u_eng_i ( // see R3
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .cal_tick_i(tick),
    .start_i(mem_ctrl_reg[DSC_START_BIT] && cal_ctrl_reg[DSC_TGT_I_BIT]), // see R7
    .clear_i(mem_clear), // see R6
    .coef_addr_i(coef_index),
    .coef_we_i(we_i),
    .coef_wdata_i(bus.wdata[5:0]),
    .coef_rdata_o(rdata_i),
    .done_o(done_i),
    .uncal_o(uncal_i)
  );
  // Q channel engine, wired as the I engine but gated by the Q target bit
  dsc_cal_engine u_eng_q (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .cal_tick_i(tick),
    .start_i(mem_ctrl_reg[DSC_START_BIT] && cal_ctrl_reg[DSC_TGT_Q_BIT]),
    .clear_i(mem_clear),
    .coef_addr_i(coef_index),
    .coef_we_i(we_q),
    .coef_wdata_i(bus.wdata[5:0]),
    .coef_rdata_o(rdata_q),
    .done_o(done_q),
    .uncal_o(uncal_q)
  );
  // Trim outputs, signed codes for reference and coarse, binary for fine
  assign reference_trim_o = ref_trim_reg[5:0]; // see R16
  assign i_coarse_gain_code_o = i_coarse_reg[5:0]; // see R17
  assign q_coarse_gain_code_o = q_coarse_reg[5:0];
  assign i_fine_gain_o = i_fine_reg[5:0]; // see R18
  assign q_fine_gain_o = q_fine_reg[5:0];
  assign cal_clock_o = cal_clk_reg;
  // Link answer comes straight from registers
  assign bus.ack = ack_reg;
  assign bus.rdata = rdata_reg;
endmodule

//--- dsc_pkg.sv
// Shared constants and types for the self-calibration and gain trim block
package dsc_pkg;
  // Register byte addresses
  localparam logic [7:0] DSC_ADDR_I_FINE = 8'h03;
  localparam logic [7:0] DSC_ADDR_I_COARSE = 8'h04;
  localparam logic [7:0] DSC_ADDR_Q_FINE = 8'h06;
  localparam logic [7:0] DSC_ADDR_Q_COARSE = 8'h07;
  localparam logic [7:0] DSC_ADDR_REF_TRIM = 8'h0D;
  localparam logic [7:0] DSC_ADDR_CAL_CTRL = 8'h0E;
  localparam logic [7:0] DSC_ADDR_CAL_STAT = 8'h0F;
  localparam logic [7:0] DSC_ADDR_COEF_ADDR = 8'h10;
  localparam logic [7:0] DSC_ADDR_COEF_DATA = 8'h11;
  localparam logic [7:0] DSC_ADDR_MEM_CTRL = 8'h12;
  // Field positions
  localparam int DSC_CAL_CLOCK_DIVIDE_SELECT_LSB = 0;
  localparam int DSC_CLK_EN_BIT = 3;
  localparam int DSC_TGT_I_BIT = 4;
  localparam int DSC_TGT_Q_BIT = 5;
  localparam int DSC_RD_BIT = 2;
  localparam int DSC_WR_BIT = 3;
  localparam int DSC_START_BIT = 4;
  localparam int DSC_UNCAL_I_BIT = 0;
  localparam int DSC_UNCAL_Q_BIT = 1;
  localparam int DSC_DONE_I_BIT = 6;
  localparam int DSC_DONE_Q_BIT = 7;
  // Reset values and sizes
  localparam logic [7:0] DSC_RESET_VAL = 8'h00;
  localparam logic [7:0] DSC_MEM_CLEAR = 8'h00;
  localparam logic [7:0] DSC_MEM_RD_CMD = 8'h04;
  localparam logic [7:0] DSC_MEM_WR_CMD = 8'h08;
  localparam logic [7:0] DSC_FIRST_COEF = 8'h01;
  localparam int DSC_COEF_COUNT = 32;
  localparam int DSC_COEF_WIDTH = 6;
  localparam int DSC_DIV_BASE = 32;
  localparam int DSC_CAL_CLOCK_DIVIDE_SELECT_MAX = 6;
  localparam int DSC_CAL_CYCLES = 300;
  localparam int DSC_CLK_MHZ = 200;
  // Calibration clock limits in kHz
  localparam int DSC_CAL_MIN_KHZ = 500;
  localparam int DSC_CAL_MAX_KHZ = 4000;
  // Host bus sequencer states
  typedef enum logic [1:0] {
    DSC_H_IDLE = 2'b00,
    DSC_H_WRITE = 2'b01,
    DSC_H_READ = 2'b10,
    DSC_H_DONE = 2'b11
  } dsc_host_state_e;
endpackage

//--- dsc_if.sv
// Register access link between host and converter control
`timescale 1ns/1ps
interface dsc_if;
  logic req;
  logic wr;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic ack;
  logic [7:0] rdata;
  modport device (input req, input wr, input addr, input wdata, output ack, output rdata);
  modport host (output req, output wr, output addr, output wdata, input ack, input rdata);
endinterface

//--- dsc_cal_engine.sv
// One channel's calibration sequencer and coefficient store
`timescale 1ns/1ps
module dsc_cal_engine #(
  parameter int COEF_COUNT = dsc_pkg::DSC_COEF_COUNT,
  parameter int COEF_WIDTH = dsc_pkg::DSC_COEF_WIDTH,
  parameter int CAL_CYCLES = dsc_pkg::DSC_CAL_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic cal_tick_i,
  input wire logic start_i,
  input wire logic clear_i,
  input wire logic [4:0] coef_addr_i,
  input wire logic coef_we_i,
  input wire logic [COEF_WIDTH-1:0] coef_wdata_i,
  output logic [COEF_WIDTH-1:0] coef_rdata_o,
  output logic done_o,
  output logic uncal_o
);
  import dsc_pkg::*;
  // Store needs every slot of the 5-bit address; the counter reaches 1023 at most
  if (COEF_COUNT != 32 || CAL_CYCLES < 1 || CAL_CYCLES > 1024) begin : gen_bad_params
    $error("dsc_cal_engine bad params");
  end
  logic [COEF_WIDTH-1:0] coef_mem [COEF_COUNT];
  logic [9:0] count_reg, count_next;
  logic busy_reg, busy_next;
  logic done_reg, done_next;
  logic uncal_reg, uncal_next;
  logic [COEF_WIDTH-1:0] rdata_reg;
  // Sequencer next state; clear drops flags, start wins over clear
  always_comb begin
    count_next = count_reg;
    busy_next = busy_reg;
    done_next = done_reg;
    uncal_next = uncal_reg;
    if (clear_i) begin
      busy_next = 1'b0;
      done_next = 1'b0;
      uncal_next = 1'b0;
    end
    if (start_i && !busy_reg && !done_reg) begin
      busy_next = 1'b1;
      uncal_next = 1'b1;
      count_next = 10'd0;
    end else if (busy_reg && cal_tick_i) begin
      if (count_reg == 10'(CAL_CYCLES - 1)) begin
        busy_next = 1'b0;
        done_next = 1'b1; // see R8
        uncal_next = 1'b0;
      end else begin
        count_next = count_reg + 10'd1;
      end
    end
  end
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      count_reg <= 10'd0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      uncal_reg <= 1'b1;
    end else begin
      count_reg <= count_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
      uncal_reg <= uncal_next;
    end
  end
  // Coefficient store; calibration writes a trimmed index pattern per slot
  always_ff @(posedge ref_clk_i) begin
    if (coef_we_i) begin
      coef_mem[coef_addr_i] <= coef_wdata_i; // see R10
    end else if (busy_reg && cal_tick_i) begin
      coef_mem[count_reg[4:0]] <= COEF_WIDTH'(count_reg[9:5]);
    end
    rdata_reg <= coef_mem[coef_addr_i];
  end
  assign coef_rdata_o = rdata_reg;
  assign done_o = done_reg;
  assign uncal_o = uncal_reg;
endmodule

//--- dsc_host.sv
// Host side: turns one-shot user commands into link register accesses
`timescale 1ns/1ps
module dsc_host (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  dsc_if.host bus,
  input wire logic cmd_valid_i,
  input wire logic cmd_write_i,
  input wire logic [7:0] cmd_addr_i,
  input wire logic [7:0] cmd_wdata_i,
  output logic cmd_ready_o,
  output logic resp_valid_o,
  output logic [7:0] resp_data_o
);
  import dsc_pkg::*;
  // Host duties R2, R9, R14 rest with the user's command sequence
  dsc_host_state_e state_reg, state_next;
  logic req_reg, req_next, wr_reg, wr_next;
  logic [7:0] addr_reg, addr_next, wdata_reg, wdata_next, resp_reg, resp_next;
  logic rv_reg, rv_next;
  // One access at a time, held until acknowledged
  always_comb begin
    state_next = state_reg;
    req_next = req_reg;
    wr_next = wr_reg;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    resp_next = resp_reg;
    rv_next = 1'b0;
    unique case (state_reg)
      DSC_H_IDLE: begin
        if (cmd_valid_i) begin
          req_next = 1'b1;
          wr_next = cmd_write_i;
          addr_next = cmd_addr_i;
          wdata_next = cmd_wdata_i;
          state_next = cmd_write_i ? DSC_H_WRITE : DSC_H_READ; // see R19
        end
      end
      DSC_H_WRITE, DSC_H_READ: begin
        if (bus.ack) begin
          req_next = 1'b0;
          resp_next = bus.rdata;
          state_next = DSC_H_DONE;
        end
      end
      DSC_H_DONE: begin
        rv_next = 1'b1;
        state_next = DSC_H_IDLE;
      end
    endcase
  end
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state_reg <= DSC_H_IDLE;
      req_reg <= 1'b0;
      wr_reg <= 1'b0;
      addr_reg <= DSC_RESET_VAL;
      wdata_reg <= DSC_RESET_VAL;
      resp_reg <= DSC_RESET_VAL;
      rv_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      req_reg <= req_next;
      wr_reg <= wr_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      resp_reg <= resp_next;
      rv_reg <= rv_next;
    end
  end
  assign bus.req = req_reg;
  assign bus.wr = wr_reg;
  assign bus.addr = addr_reg;
  assign bus.wdata = wdata_reg;
  assign cmd_ready_o = (state_reg == DSC_H_IDLE);
  assign resp_valid_o = rv_reg;
  assign resp_data_o = resp_reg;
endmodule

//--- dsc_link_properties.sv
// Protocol and register checks on the host to device link
`timescale 1ns/1ps
module dsc_link_properties (
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic req,
  input wire logic wr,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic ack,
  input wire logic [7:0] rdata
);
  import dsc_pkg::*;
  logic take;
  logic [5:0] trim_reg, trim_next;
  logic rd_en_reg, rd_en_next;
  logic clr_reg, clr_next;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  // Request taken by the device on this edge
  assign take = req && !ack;
  // Shadow of written trim and memory control
  always_comb begin
    trim_next = trim_reg;
    rd_en_next = rd_en_reg;
    clr_next = clr_reg;
    if (take && wr && addr == DSC_ADDR_REF_TRIM) begin
      trim_next = wdata[5:0];
    end
    if (take && wr && addr == DSC_ADDR_MEM_CTRL) begin
      rd_en_next = wdata[DSC_RD_BIT];
      clr_next = (wdata == DSC_MEM_CLEAR);
    end
  end
  // Shadow registers
  always_ff @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      trim_reg <= 6'h00;
      rd_en_reg <= 1'b0;
      clr_reg <= 1'b0;
    end else begin
      trim_reg <= trim_next;
      rd_en_reg <= rd_en_next;
      clr_reg <= clr_next;
    end
  end
  // Read of one address taken under a condition
  sequence s_rd(logic [7:0] a, logic c);
    take && !wr && addr == a && c;
  endsequence
  chk_answer_next: assert property (take |=> ack)
    else $error("link request not answered next cycle");
  chk_ack_single: assert property (ack |=> !ack && !req)
    else $error("link ack or request held too long");
  chk_ack_cause: assert property (ack |-> $past(take))
    else $error("link ack without request");
  chk_req_stable: assert property (take |=> $stable(addr) && $stable(wr) && $stable(wdata))
    else $error("link request changed before ack");
  chk_trim_readback: assert property (s_rd(DSC_ADDR_REF_TRIM, 1'b1) |=> rdata == {2'b00, trim_reg})
    else $error("trim read differs from last write");
  chk_coef_gated: assert property (s_rd(DSC_ADDR_COEF_DATA, !rd_en_reg) |=> rdata == 8'h00)
    else $error("coefficient data visible without read bit");
  chk_clear_status: assert property (s_rd(DSC_ADDR_CAL_STAT, clr_reg) |=> rdata == 8'h00)
    else $error("status not cleared by memory control zero");
  chk_unmapped_zero: assert property (take && !wr && addr > DSC_ADDR_MEM_CTRL |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  chk_gain_upper: assert property (take && !wr && addr inside {8'h03, 8'h04, 8'h06, 8'h07}
    |=> rdata[7:6] == 2'b00)
    else $error("gain register upper bits set");
endmodule

//--- dsc_self_cal_gain_trim_test.sv
// Self-checking bench: host end drives device end over the link
`timescale 1ns/1ps
module dsc_self_cal_gain_trim_test;
  import dsc_pkg::*;
  typedef struct packed { logic [7:0] a; logic [7:0] d; logic [7:0] e; } dsc_row_s;
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic cmd_valid_i = 1'b0, cmd_write_i = 1'b0;
  logic [7:0] cmd_addr_i = 8'h00, cmd_wdata_i = 8'h00, resp_data_o, rd;
  logic cmd_ready_o, resp_valid_o, cal_clock_o;
  logic signed [5:0] reference_trim_o, i_coarse_gain_code_o, q_coarse_gain_code_o;
  logic [5:0] i_fine_gain_o, q_fine_gain_o;
  int n_mismatch = 0, checked = 0, n, p, i, cyc = 0, t0;
  dsc_row_s rows [10] = '{'{8'h03, 8'hFF, 8'h3F}, '{8'h04, 8'hA5, 8'h25},
    '{8'h06, 8'h2A, 8'h2A}, '{8'h07, 8'h20, 8'h20}, '{8'h0D, 8'h1F, 8'h1F},
    '{8'h0D, 8'hE0, 8'h20}, '{8'h0E, 8'hC7, 8'h07}, '{8'h0F, 8'hFF, 8'h03},
    '{8'h05, 8'h77, 8'h00}, '{8'h13, 8'h5A, 8'h00}};
  dsc_if link();
  dsc_device dsc_device_inst (.ref_clk_i, .reset_i, .bus(link), .reference_trim_o,
    .i_coarse_gain_code_o, .q_coarse_gain_code_o, .i_fine_gain_o, .q_fine_gain_o, .cal_clock_o);
  dsc_host dsc_host_inst (.ref_clk_i, .reset_i, .bus(link), .cmd_valid_i, .cmd_write_i,
    .cmd_addr_i, .cmd_wdata_i, .cmd_ready_o, .resp_valid_o, .resp_data_o);
  dsc_link_properties dsc_link_properties_inst (.ref_clk_i, .reset_i, .req(link.req),
    .wr(link.wr), .addr(link.addr), .wdata(link.wdata), .ack(link.ack), .rdata(link.rdata));
  // Clock and cycle count
  initial forever #2.5 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) cyc <= cyc + 1;
  task automatic cmp_byte(string nm, logic [7:0] e, logic [7:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmp_int(string nm, int e, int g);
    checked++;
    if (g != e) begin
      n_mismatch++;
      $display("wrong value %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  // One user command, waits for the response pulse
  task automatic op(logic w, logic [7:0] a, logic [7:0] d);
    n = 0;
    while (cmd_ready_o !== 1'b1 && n < 50) begin @(negedge ref_clk_i); n++; end
    @(posedge ref_clk_i);
    cmd_valid_i <= 1'b1;
    cmd_write_i <= w;
    cmd_addr_i <= a;
    cmd_wdata_i <= d;
    @(posedge ref_clk_i);
    cmd_valid_i <= 1'b0;
    n = 0;
    do begin @(negedge ref_clk_i); n++; end while (resp_valid_o !== 1'b1 && n < 20);
    if (n >= 20) n_mismatch++;
    rd = resp_data_o;
  endtask
  task automatic rdchk(string nm, logic [7:0] a, logic [7:0] e);
    op(1'b0, a, 8'h00);
    cmp_byte(nm, e, rd);
  endtask
  task automatic coef_rd(string nm, logic [7:0] sel, logic [7:0] a, logic [7:0] e);
    op(1'b1, DSC_ADDR_CAL_CTRL, sel);
    op(1'b1, DSC_ADDR_COEF_ADDR, a);
    op(1'b1, DSC_ADDR_MEM_CTRL, DSC_MEM_RD_CMD);
    rdchk(nm, DSC_ADDR_COEF_DATA, e);
    op(1'b1, DSC_ADDR_MEM_CTRL, DSC_MEM_CLEAR);
  endtask
  task automatic wait_lvl(logic v);
    n = 0;
    while (cal_clock_o !== v && n < 5000) begin @(negedge ref_clk_i); n++; end
  endtask
  // Cycles from one rising calibration clock edge to the next
  task automatic period(output int q);
    wait_lvl(1'b0);
    wait_lvl(1'b1);
    q = 0;
    while (cal_clock_o === 1'b1 && q < 5000) begin @(negedge ref_clk_i); q++; end
    while (cal_clock_o === 1'b0 && q < 5000) begin @(negedge ref_clk_i); q++; end
  endtask
  task automatic close_out();
    if (n_mismatch == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (5) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    rdchk("cal ctrl", DSC_ADDR_CAL_CTRL, 8'h00);
    rdchk("status", DSC_ADDR_CAL_STAT, 8'h03);
    foreach (rows[i]) begin
      op(1'b1, rows[i].a, rows[i].d);
      rdchk("register", rows[i].a, rows[i].e);
    end
    @(negedge ref_clk_i);
    cmp_byte("i fine", 8'h3F, {2'b00, i_fine_gain_o});
    cmp_byte("i coarse", 8'h25, {2'b00, i_coarse_gain_code_o});
    cmp_byte("q fine", 8'h2A, {2'b00, q_fine_gain_o});
    cmp_byte("q coarse", 8'h20, {2'b00, q_coarse_gain_code_o});
    cmp_byte("trim", 8'h20, {2'b00, reference_trim_o});
    for (i = 0; i < 8; i++) begin
      op(1'b1, DSC_ADDR_CAL_CTRL, 8'h08 | i[7:0]);
      period(p);
      period(p);
      cmp_int("cal period", 32 << (i > 6 ? 6 : i), p);
    end
    op(1'b1, DSC_ADDR_CAL_CTRL, 8'h00);
    p = 0;
    repeat (100) begin @(negedge ref_clk_i); p += (cal_clock_o !== 1'b0); end
    cmp_int("idle cal clock", 0, p);
    op(1'b1, DSC_ADDR_MEM_CTRL, DSC_MEM_CLEAR);
    rdchk("cleared status", DSC_ADDR_CAL_STAT, 8'h00);
    op(1'b1, DSC_ADDR_CAL_CTRL, 8'h39);
    t0 = cyc;
    op(1'b1, DSC_ADDR_MEM_CTRL, 8'h10);
    p = 0;
    do begin op(1'b0, DSC_ADDR_CAL_STAT, 8'h00); p++; end while (rd[7:6] !== 2'b11 && p < 4000);
    cmp_byte("done bits", 8'hC0, rd & 8'hC0);
    // Select 1 gives 64-cycle ticks: 300 of them plus link overhead
    cmp_int("cal span", 1, int'(cyc - t0 >= 19136 && cyc - t0 <= 19300));
    op(1'b1, DSC_ADDR_MEM_CTRL, DSC_MEM_CLEAR);
    rdchk("status after", DSC_ADDR_CAL_STAT, 8'h00);
    // I channel alone, then aborted by the clearing write
    op(1'b1, DSC_ADDR_CAL_CTRL, 8'h19);
    op(1'b1, DSC_ADDR_MEM_CTRL, 8'h10);
    rdchk("i alone status", DSC_ADDR_CAL_STAT, 8'h01);
    op(1'b1, DSC_ADDR_MEM_CTRL, DSC_MEM_CLEAR);
    rdchk("abort status", DSC_ADDR_CAL_STAT, 8'h00);
    op(1'b1, DSC_ADDR_CAL_CTRL, 8'h10);
    op(1'b1, DSC_ADDR_MEM_CTRL, DSC_MEM_WR_CMD);
    op(1'b1, DSC_ADDR_COEF_ADDR, DSC_FIRST_COEF);
    op(1'b1, DSC_ADDR_COEF_DATA, 8'h2A);
    op(1'b1, DSC_ADDR_COEF_ADDR, 8'h20);
    op(1'b1, DSC_ADDR_COEF_DATA, 8'hD5);
    op(1'b1, DSC_ADDR_CAL_CTRL, 8'h20);
    op(1'b1, DSC_ADDR_COEF_ADDR, DSC_FIRST_COEF);
    op(1'b1, DSC_ADDR_COEF_DATA, 8'h07);
    op(1'b1, DSC_ADDR_MEM_CTRL, DSC_MEM_CLEAR);
    coef_rd("i coef first", 8'h10, DSC_FIRST_COEF, 8'h2A);
    coef_rd("i coef last", 8'h10, 8'h20, 8'h15);
    coef_rd("q coef first", 8'h20, DSC_FIRST_COEF, 8'h07);
    rdchk("gated coef", DSC_ADDR_COEF_DATA, 8'h00);
    op(1'b1, DSC_ADDR_CAL_CTRL, 8'h00);
    @(posedge ref_clk_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    @(negedge ref_clk_i);
    cmp_byte("trim after reset", 8'h00, {2'b00, reference_trim_o});
    rdchk("status after reset", DSC_ADDR_CAL_STAT, 8'h03);
    close_out();
  end
  // Watchdog against a hang
  initial begin
    repeat (80000) @(posedge ref_clk_i);
    n_mismatch++;
    close_out();
  end
endmodule
